// file: htc_host.sv
`timescale 1ns/1ps
`default_nettype none
module htc_host (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    output var logic [3:0] addr_out,
    output var logic [15:0] wdata_out,
    output var logic wr_out,
    output var logic rd_out
);
    initial begin
        addr_out = 4'h0;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // Fabric master; one strobe cycle, then one idle cycle
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
        @(posedge clk_in);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1 d = rdata_in;
        @(posedge clk_in);
    endtask : rd
endmodule : htc_host
`default_nettype wire

// file: htc_map.svh
`ifndef HTC_MAP_SVH
`define HTC_MAP_SVH
`define HTC_ADDR_W 4
`define HTC_OFS_CTRL 4'h0
`define HTC_OFS_PRESC 4'h1
`define HTC_OFS_TOP 4'h2
`define HTC_OFS_CMP 4'h3
`define HTC_OFS_CNT 4'h4
`define HTC_OFS_CAP 4'h5
`define HTC_OFS_IRQEN 4'h6
`define HTC_OFS_IRQST 4'h7
`define HTC_OFS_ID 4'h8
`define HTC_ID_VALUE 16'h5a01
`define HTC_CTRL_RST 16'h0000
`define HTC_PRESC_RST 16'h0000
`define HTC_TOP_RST 16'hffff
`define HTC_CMP_RST 16'h8000
`define HTC_CNT_ZERO 16'h0000
`define HTC_CNT_ONE 16'h0001
`define HTC_CNT_MAX 16'hffff
`define HTC_BIT_EN 0
`define HTC_BIT_MODE_LO 1
`define HTC_BIT_MODE_HI 2
`define HTC_BIT_CLKSEL 3
`define HTC_BIT_CAPEN 4
`define HTC_BIT_INV 5
`define HTC_IRQ_OVF 0
`define HTC_IRQ_CMP 1
`define HTC_IRQ_CAP 2
`endif

// file: htc_pkg.sv
package htc_pkg;
    typedef enum logic [1:0] {
        HTC_MODE_WDT = 2'h0,
        HTC_MODE_CTC = 2'h1,
        HTC_MODE_FPWM = 2'h2,
        HTC_MODE_PFC = 2'h3
    } htc_mode_t;
    typedef enum logic [1:0] {
        HTC_DIR_UP = 2'h1,
        HTC_DIR_DOWN = 2'h2
    } htc_dir_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } htc_bus_req_t;
    typedef struct packed {
        logic inv;
        logic cap_en;
        logic clk_sel;
        htc_mode_t mode;
        logic enable;
    } htc_ctrl_t;
endpackage : htc_pkg

// file: htc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module htc_sync (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic async_in,
    output logic level_out
);
    logic [2:0] stage_q;
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            stage_q <= 3'h0;
        end else begin
            stage_q <= {stage_q[1:0], async_in};
        end
    end
    // Change is accepted once the second and third stages agree
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            level_out <= 1'b0;
        end else if (stage_q[1] == stage_q[2]) begin
            level_out <= stage_q[2];
        end
    end
endmodule : htc_sync
`default_nettype wire

// file: htc_timer.sv
// Notes on behaviour
// - Sixteen-bit up/down counter with compare and PWM
// - Watchdog, clear-on-match, fast PWM, phase- and frequency-correct PWM
// - Selectable count clock through programmable prescaler
// - Overflow, compare and capture interrupt sources
// - Synchronised capture edge stores count value
// - Capture only in non-PWM modes with bus
// - Without bus, interrupt equals overflow flag
// - With bus, interrupt follows enable registers
// - Static interrupt plus separate wake-up interrupt
// - Registers reachable over bus slave port
// - Stand-alone mode uses preloaded registers, pin reset
// - Reset pin always enabled by preloaded bit
// - Glitch-free variable-period PWM on output pin
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "htc_map.svh"
module htc_timer
    import htc_pkg::*;
#(
    parameter logic [15:0] PRE_CTRL = `HTC_CTRL_RST,
    parameter logic [15:0] PRE_PRESC = `HTC_PRESC_RST,
    parameter logic [15:0] PRE_TOP = `HTC_TOP_RST,
    parameter logic [15:0] PRE_CMP = `HTC_CMP_RST
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic timer_reset_n_in,
    input wire logic bus_enable_cfg_in,
    input wire logic timer_clock_in,
    input wire logic capture_trigger_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic timer_irq_out,
    output logic wake_irq_out,
    output logic compare_wave_out,
    output logic [15:0] counter_value_out
);
    localparam logic reset_pin_enable_cfg = 1'b1;

    htc_bus_req_t req;
    htc_ctrl_t ctrl_q;
    logic [15:0] presc_q;
    logic [15:0] top_q;
    logic [15:0] cmp_q;
    logic [15:0] top_act_q;
    logic [15:0] cmp_act_q;
    logic [15:0] counter_value_q;
    logic [15:0] capture_timestamp_reg_q;
    logic [15:0] div_q;
    logic [2:0] irq_en_q;
    logic [2:0] irq_st_q;
    logic dir_down_q;
    logic ext_clk_lvl;
    logic ext_clk_prev_q;
    logic cap_lvl;
    logic cap_prev_q;
    logic src_tick;
    logic tick;
    logic ovf_ev;
    logic cmp_ev;
    logic cap_ev;
    logic pwm_mode;
    logic wave_q;
    logic wave_d;
    logic timer_rst;
    logic [15:0] cnt_d;
    logic dir_d;

    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

    function automatic logic hit(input htc_bus_req_t r, input logic [3:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction : hit

    function automatic logic is_pwm(input htc_mode_t m);
        is_pwm = (m == HTC_MODE_FPWM) || (m == HTC_MODE_PFC);
    endfunction : is_pwm

    // Pin reset stays enabled by the preloaded enable bit
    assign timer_rst = !resetn_in || (reset_pin_enable_cfg && !timer_reset_n_in);
    assign pwm_mode = is_pwm(ctrl_q.mode);

    htc_sync u_sync_clk (
        .clk_in(clk_sys_in),
        .resetn_in(resetn_in),
        .async_in(timer_clock_in),
        .level_out(ext_clk_lvl)
    );

    htc_sync u_sync_cap (
        .clk_in(clk_sys_in),
        .resetn_in(resetn_in),
        .async_in(capture_trigger_in),
        .level_out(cap_lvl)
    );

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            ext_clk_prev_q <= 1'b0;
            cap_prev_q <= 1'b0;
        end else begin
            ext_clk_prev_q <= ext_clk_lvl;
            cap_prev_q <= cap_lvl;
        end
    end

    // Clock source select then prescaler
    assign src_tick = ctrl_q.clk_sel ? (ext_clk_lvl && !ext_clk_prev_q) : 1'b1;
    // Divider wraps at or beyond the limit, so a smaller prescaler never stalls it
    assign tick = ctrl_q.enable && src_tick && (div_q >= presc_q);

    always_ff @(posedge clk_sys_in) begin
        if (timer_rst) begin
            div_q <= `HTC_CNT_ZERO;
        end else if (ctrl_q.enable && src_tick) begin
            div_q <= (div_q >= presc_q) ? `HTC_CNT_ZERO : div_q + `HTC_CNT_ONE;
        end
    end

    // Control registers: preloaded values, bus writes only when bus in use
    always_ff @(posedge clk_sys_in) begin
        if (timer_rst) begin
            ctrl_q <= PRE_CTRL[5:0];
            presc_q <= PRE_PRESC;
            top_q <= PRE_TOP;
            cmp_q <= PRE_CMP;
            irq_en_q <= 3'h0;
        end else if (bus_enable_cfg_in) begin
            if (hit(req, `HTC_OFS_CTRL)) begin
                ctrl_q <= req.wdata[5:0];
            end
            if (hit(req, `HTC_OFS_PRESC)) begin
                presc_q <= req.wdata;
            end
            if (hit(req, `HTC_OFS_TOP)) begin
                top_q <= req.wdata;
            end
            if (hit(req, `HTC_OFS_CMP)) begin
                cmp_q <= req.wdata;
            end
            if (hit(req, `HTC_OFS_IRQEN)) begin
                irq_en_q <= req.wdata[2:0];
            end
        end
    end

    // Counter next state per mode
    always_comb begin
        cnt_d = counter_value_q;
        dir_d = dir_down_q;
        ovf_ev = 1'b0;
        cmp_ev = 1'b0;
        case (ctrl_q.mode)
            HTC_MODE_WDT: begin
                ovf_ev = (counter_value_q == `HTC_CNT_MAX);
                cnt_d = counter_value_q + `HTC_CNT_ONE;
                cmp_ev = (counter_value_q == cmp_act_q);
            end
            HTC_MODE_CTC: begin
                if (counter_value_q == cmp_act_q) begin
                    cnt_d = `HTC_CNT_ZERO;
                    cmp_ev = 1'b1;
                end else begin
                    cnt_d = counter_value_q + `HTC_CNT_ONE;
                end
                ovf_ev = (counter_value_q == `HTC_CNT_MAX);
            end
            HTC_MODE_FPWM: begin
                if (counter_value_q >= top_act_q) begin
                    cnt_d = `HTC_CNT_ZERO;
                    ovf_ev = 1'b1;
                end else begin
                    cnt_d = counter_value_q + `HTC_CNT_ONE;
                end
                cmp_ev = (counter_value_q == cmp_act_q);
            end
            HTC_MODE_PFC: begin
                if (!dir_down_q) begin
                    if (counter_value_q >= top_act_q) begin
                        dir_d = 1'b1;
                        cnt_d = counter_value_q - `HTC_CNT_ONE;
                    end else begin
                        cnt_d = counter_value_q + `HTC_CNT_ONE;
                    end
                end else begin
                    if (counter_value_q == `HTC_CNT_ZERO) begin
                        dir_d = 1'b0;
                        ovf_ev = 1'b1;
                        cnt_d = `HTC_CNT_ONE;
                    end else begin
                        cnt_d = counter_value_q - `HTC_CNT_ONE;
                    end
                end
                cmp_ev = (counter_value_q == cmp_act_q);
            end
            default: begin
                cnt_d = `HTC_CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (timer_rst) begin
            counter_value_q <= `HTC_CNT_ZERO;
            dir_down_q <= 1'b0;
        end else if (hit(req, `HTC_OFS_CNT) && bus_enable_cfg_in) begin
            counter_value_q <= req.wdata;
            dir_down_q <= 1'b0;
        end else if (tick) begin
            counter_value_q <= cnt_d;
            dir_down_q <= dir_d;
        end
    end

    // Period and compare are double-buffered; loaded at period end so PWM never glitches
    always_ff @(posedge clk_sys_in) begin
        if (timer_rst) begin
            top_act_q <= PRE_TOP;
            cmp_act_q <= PRE_CMP;
        end else if (!pwm_mode || !ctrl_q.enable || (tick && ovf_ev)) begin
            top_act_q <= top_q;
            cmp_act_q <= cmp_q;
        end
    end

    // Waveform: registered output
    always_comb begin
        wave_d = wave_q;
        case (ctrl_q.mode)
            HTC_MODE_FPWM: wave_d = (cnt_d < cmp_act_q);
            HTC_MODE_PFC: wave_d = (cnt_d < cmp_act_q);
            HTC_MODE_CTC: wave_d = cmp_ev ? !wave_q : wave_q;
            default: wave_d = wave_q;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (timer_rst) begin
            wave_q <= 1'b0;
        end else if (tick) begin
            wave_q <= wave_d;
        end
    end

    // Input capture only in non-PWM modes with bus
    assign cap_ev = cap_lvl && !cap_prev_q && ctrl_q.cap_en && !pwm_mode && bus_enable_cfg_in;

    always_ff @(posedge clk_sys_in) begin
        if (timer_rst) begin
            capture_timestamp_reg_q <= `HTC_CNT_ZERO;
        end else if (cap_ev) begin
            capture_timestamp_reg_q <= counter_value_q;
        end
    end

    // Sticky status: set wins over write-one-to-clear
    always_ff @(posedge clk_sys_in) begin
        if (timer_rst) begin
            irq_st_q <= 3'h0;
        end else begin
            irq_st_q[`HTC_IRQ_OVF] <= (tick && ovf_ev) ||
                (irq_st_q[`HTC_IRQ_OVF] && !(hit(req, `HTC_OFS_IRQST) && req.wdata[`HTC_IRQ_OVF]));
            irq_st_q[`HTC_IRQ_CMP] <= (tick && cmp_ev) ||
                (irq_st_q[`HTC_IRQ_CMP] && !(hit(req, `HTC_OFS_IRQST) && req.wdata[`HTC_IRQ_CMP]));
            irq_st_q[`HTC_IRQ_CAP] <= cap_ev ||
                (irq_st_q[`HTC_IRQ_CAP] && !(hit(req, `HTC_OFS_IRQST) && req.wdata[`HTC_IRQ_CAP]));
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (timer_rst) begin
            timer_irq_out <= 1'b0;
            wake_irq_out <= 1'b0;
        end else begin
            timer_irq_out <= bus_enable_cfg_in ? |(irq_st_q & irq_en_q) : irq_st_q[`HTC_IRQ_OVF];
            wake_irq_out <= |irq_st_q;
        end
    end

    // Read port: data in the cycle after the strobe
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= `HTC_CNT_ZERO;
        end else if (req.rd) begin
            case (req.addr)
                `HTC_OFS_CTRL: reg_rdata_out <= {10'h000, ctrl_q};
                `HTC_OFS_PRESC: reg_rdata_out <= presc_q;
                `HTC_OFS_TOP: reg_rdata_out <= top_q;
                `HTC_OFS_CMP: reg_rdata_out <= cmp_q;
                `HTC_OFS_CNT: reg_rdata_out <= counter_value_q;
                `HTC_OFS_CAP: reg_rdata_out <= capture_timestamp_reg_q;
                `HTC_OFS_IRQEN: reg_rdata_out <= {13'h0000, irq_en_q};
                `HTC_OFS_IRQST: reg_rdata_out <= {12'h000, dir_down_q, irq_st_q};
                `HTC_OFS_ID: reg_rdata_out <= `HTC_ID_VALUE;
                default: reg_rdata_out <= `HTC_CNT_ZERO;
            endcase
        end else begin
            reg_rdata_out <= `HTC_CNT_ZERO;
        end
    end

    assign compare_wave_out = wave_q ^ ctrl_q.inv;
    assign counter_value_out = counter_value_q;
endmodule : htc_timer
`default_nettype wire

// file: htc_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "htc_map.svh"
module htc_timer_bench;
    import htc_pkg::*;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic trst_n = 1'b1;
    logic bus_en = 1'b1;
    logic tclk = 1'b0;
    logic trig = 1'b0;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, cnt;
    logic wr, rd, irq, wake, wave;
    int fails = 0;
    int checks = 0;
    always #2.5 clk_sys_in = ~clk_sys_in;
    htc_timer dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .timer_reset_n_in(trst_n),
        .bus_enable_cfg_in(bus_en), .timer_clock_in(tclk), .capture_trigger_in(trig), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .timer_irq_out(irq),
        .wake_irq_out(wake), .compare_wave_out(wave), .counter_value_out(cnt));
    htc_host host (.clk_in(clk_sys_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.rd(a, d);
        check(d, exp);
    endtask : rchk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : tick
    task automatic t_regs;
        rchk(4'h0, `HTC_CTRL_RST);
        rchk(4'h1, `HTC_PRESC_RST);
        rchk(4'h2, `HTC_TOP_RST);
        rchk(4'h3, `HTC_CMP_RST);
        host.wr(4'h8, 16'h0000);
        rchk(4'h8, `HTC_ID_VALUE);
        rchk(4'hf, 16'h0000);
    endtask : t_regs
    task automatic t_wrap;
        host.wr(4'h6, 16'h0001);
        host.wr(4'h4, 16'hfffc);
        host.wr(4'h0, 16'h0001);
        tick(10);
        host.wr(4'h0, 16'h0000);
        check({15'h0, cnt < 16'h0010}, 16'h0001);
        check({15'h0, irq}, 16'h0001);
        rchk(4'h7, 16'h0001);
        host.wr(4'h7, 16'h000f);
        tick(2);
        check({14'h0, irq, wake}, 16'h0000);
    endtask : t_wrap
    task automatic t_ctc;
        logic [15:0] top;
        top = 16'h0000;
        host.wr(4'h4, 16'h0000);
        host.wr(4'h3, 16'h0005);
        host.wr(4'h6, 16'h0002);
        host.wr(4'h0, 16'h0003);
        repeat (30) begin
            @(posedge clk_sys_in);
            if (cnt > top) top = cnt;
        end
        host.wr(4'h0, 16'h0000);
        check(top, 16'h0005);
        rchk(4'h7, 16'h0002);
        check({15'h0, irq}, 16'h0001);
        host.wr(4'h7, 16'h000f);
    endtask : t_ctc
    task automatic t_clock;
        host.wr(4'h4, 16'h0000);
        host.wr(4'h1, 16'h0001);
        host.wr(4'h0, 16'h0001);
        tick(40);
        host.wr(4'h0, 16'h0000);
        check({15'h0, cnt >= 16'h0013 && cnt <= 16'h0017}, 16'h0001);
        host.wr(4'h1, 16'h0000);
        host.wr(4'h4, 16'h0000);
        host.wr(4'h0, 16'h0009);
        repeat (5) begin
            tclk <= 1'b1;
            tick(4);
            tclk <= 1'b0;
            tick(4);
        end
        host.wr(4'h0, 16'h0000);
        check(cnt, 16'h0005);
    endtask : t_clock
    task automatic t_capture;
        logic [15:0] d;
        host.wr(4'h6, 16'h0004);
        host.wr(4'h0, 16'h0011);
        trig <= 1'b1;
        tick(12);
        trig <= 1'b0;
        host.wr(4'h0, 16'h0000);
        host.wr(4'h7, 16'h0003);
        rchk(4'h7, 16'h0004);
        check({15'h0, irq}, 16'h0001);
        host.rd(4'h5, d);
        check({15'h0, d != 16'h0000}, 16'h0001);
        host.wr(4'h7, 16'h000f);
    endtask : t_capture
    task automatic t_pwm;
        logic [15:0] n, top, prev;
        logic dn;
        host.wr(4'h6, 16'h0000);
        host.wr(4'h2, 16'h0009);
        host.wr(4'h3, 16'h0003);
        host.wr(4'h4, 16'h0000);
        host.wr(4'h0, 16'h0015);
        trig <= 1'b1;
        tick(20);
        trig <= 1'b0;
        n = 16'h0000;
        repeat (10) begin
            @(posedge clk_sys_in);
            n = n + {15'h0, wave};
        end
        check(n, 16'h0003);
        rchk(4'h7, 16'h0003);
        host.wr(4'h0, 16'h0017);
        top = 16'h0000;
        prev = cnt;
        dn = 1'b0;
        repeat (40) begin
            @(posedge clk_sys_in);
            if (cnt > top) top = cnt;
            if (cnt < prev) dn = 1'b1;
            prev = cnt;
        end
        host.wr(4'h0, 16'h0000);
        check(top, 16'h0009);
        check({15'h0, dn}, 16'h0001);
        host.wr(4'h7, 16'h000f);
    endtask : t_pwm
    task automatic t_alone;
        host.wr(4'h4, 16'hfff0);
        host.wr(4'h0, 16'h0001);
        bus_en <= 1'b0;
        host.wr(4'h4, 16'h1234);
        tick(30);
        check({15'h0, irq}, 16'h0001);
        check({15'h0, cnt < 16'h0100}, 16'h0001);
        trst_n <= 1'b0;
        tick(1);
        trst_n <= 1'b1;
        tick(3);
        check(cnt, 16'h0000);
        check({15'h0, irq}, 16'h0000);
    endtask : t_alone
    task automatic wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #20000;
        fails++;
        wrap_up;
    end
    initial begin
        tick(6);
        resetn_in <= 1'b1;
        tick(1);
        t_regs;
        t_wrap;
        t_ctc;
        t_clock;
        t_capture;
        t_pwm;
        t_alone;
        wrap_up;
    end
endmodule : htc_timer_bench
bind htc_timer htc_timer_props #(.PRE_CTRL(PRE_CTRL), .PRE_PRESC(PRE_PRESC), .PRE_CMP(PRE_CMP)) props (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .timer_reset_n_in(timer_reset_n_in),
    .bus_enable_cfg_in(bus_enable_cfg_in), .timer_clock_in(timer_clock_in), .capture_trigger_in(capture_trigger_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .timer_irq_out(timer_irq_out), .wake_irq_out(wake_irq_out),
    .compare_wave_out(compare_wave_out), .counter_value_out(counter_value_out));
`default_nettype wire

// file: htc_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "htc_map.svh"
module htc_timer_props
    import htc_pkg::*;
#(
    parameter logic [15:0] PRE_CTRL = 16'h0000,
    parameter logic [15:0] PRE_PRESC = 16'h0000,
    parameter logic [15:0] PRE_CMP = 16'h8000
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic timer_reset_n_in,
    input wire logic bus_enable_cfg_in,
    input wire logic timer_clock_in,
    input wire logic capture_trigger_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic timer_irq_out,
    input wire logic wake_irq_out,
    input wire logic compare_wave_out,
    input wire logic [15:0] counter_value_out
);
    logic [15:0] ctrl_q, presc_q, cmp_q;
    logic [1:0] mode;
    logic rst_ok, wr_ok, run;
    assign rst_ok = resetn_in && timer_reset_n_in;
    assign wr_ok = reg_wr_in && bus_enable_cfg_in;
    assign mode = ctrl_q[2:1];
    assign run = ctrl_q[0] && !ctrl_q[3] && presc_q == 16'h0000 && !reg_wr_in;
    // Mirror of the control, prescaler and compare registers seen from the bus
    always_ff @(posedge clk_sys_in) begin
        if (!rst_ok) begin
            ctrl_q <= PRE_CTRL;
            presc_q <= PRE_PRESC;
            cmp_q <= PRE_CMP;
        end else if (wr_ok && reg_addr_in == `HTC_OFS_CTRL) begin
            ctrl_q <= reg_wdata_in;
        end else if (wr_ok && reg_addr_in == `HTC_OFS_PRESC) begin
            presc_q <= reg_wdata_in;
        end else if (wr_ok && reg_addr_in == `HTC_OFS_CMP) begin
            cmp_q <= reg_wdata_in;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_ok);
    a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data not idle");
    a_id_read: assert property (reg_rd_in && reg_addr_in == `HTC_OFS_ID |=> reg_rdata_out == `HTC_ID_VALUE)
        else $error("id read wrong");
    a_reset_pin: assert property (disable iff (1'b0) !timer_reset_n_in |=> counter_value_out == 16'h0000 && !timer_irq_out)
        else $error("pin reset missed");
    a_count_step: assert property (run && mode == 2'h0 |=> counter_value_out == $past(counter_value_out) + 16'h0001)
        else $error("count step wrong");
    a_hold_off: assert property (!ctrl_q[0] && !reg_wr_in |=> $stable(counter_value_out))
        else $error("count moved while off");
    a_ctc_clear: assert property (run && mode == 2'h1 && counter_value_out == cmp_q |=> counter_value_out == 16'h0000 ##[0:1] wake_irq_out)
        else $error("match clear wrong");
    a_presc_hold: assert property (ctrl_q[0] && !ctrl_q[3] && presc_q == 16'h0001 && !reg_wr_in && $changed(counter_value_out) |=> $stable(counter_value_out))
        else $error("prescaler ignored");
    a_capture_flag: assert property (bus_enable_cfg_in && ctrl_q[4] && !mode[1] && $rose(capture_trigger_in) |-> ##[2:10] wake_irq_out)
        else $error("capture not flagged");
    a_fpwm_wave: assert property (mode == 2'h2 && $past(mode) == 2'h2 && !ctrl_q[5] |-> compare_wave_out == (counter_value_out < cmp_q))
        else $error("pwm level wrong");
    a_irq_wake: assert property (timer_irq_out |-> wake_irq_out || $past(wake_irq_out))
        else $error("irq without wake");
    c_ctc: cover property (run && mode == 2'h1 && counter_value_out == cmp_q);
    c_cap: cover property (ctrl_q[4] && $rose(capture_trigger_in));
    c_pwm: cover property (mode == 2'h2 && compare_wave_out);
endmodule : htc_timer_props
`default_nettype wire
